/* File: serial_frame_cfg.sv */
// Purpose: Frame format and baud configuration with a small serial engine
// Assumes: rxd synchronous to clk; APB master holds requests until pready
// Notes:   One wait state on every APB access
// Contract
// R1 - Received ninth bit readable at control B bit 1; read before data.
// R2 - Ninth transmit bit taken from control B bit 0; write before data.
// R3 - Shared-location write with bit 7 set updates frame format; reads 1.
// R4 - Shared-location write with bit 7 clear updates divisor high; reads 0.
// R5 - Mode bit 6 selects asynchronous when zero, synchronous when one.
// R6 - Parity field: 00 off, 01 reserved, 10 even, 11 odd.
// R7 - Transmitter computes and inserts parity in every frame when enabled.
// R8 - Receiver checks parity against odd select; mismatch sets parity error.
// R9 - Stop select bit 3 gives one or two transmitted stop bits.
// R10 - Receiver ignores stop count selection entirely.
// R11 - Three-bit size code gives 5 to 9 bits, both directions.
// R12 - Software keeps clock polarity zero in asynchronous mode.
// R13 - Sync polarity zero: transmit on rising, sample on falling; one swaps.
// R14 - Divisor is 12 bits: high register 4 bits, low register 8 bits.
// R15 - Writing divisor low reloads the prescaler at once.
// R16 - Software avoids changing the divisor during a frame.
// R17 - Divisor high bits 14:12 are read-only zero.
// R18 - Double speed cuts async prescale from 16 to 8.
// R19 - Unused upper data bits ignored on transmit, zero on receive.
// R20 - Async bit rate is clock over prescale times divisor plus one.
// R21 - Frame format writes never touch the divisor.
`timescale 1ns/1ps
module serial_frame_cfg (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             xck_out,
  output logic             xck_oe_n
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [6:0]  ffc_r, ffc_nxt;
  logic [11:0] div_r, div_nxt;
  logic        rxen_r, rxen_nxt, txen_r, txen_nxt, csz2_r, csz2_nxt;
  logic        tx9_r, tx9_nxt, u2x_r, u2x_nxt, shsel_r, shsel_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [11:0] pre_r, pre_nxt;
  logic        xck_r, xck_nxt, xoe_n_r, xoe_n_nxt;
  logic [3:0]  txos_r, txos_nxt, rxos_r, rxos_nxt;
  serial_cfg_pkg::tx_state_t tst_r, tst_nxt;
  serial_cfg_pkg::rx_state_t rst_r, rst_nxt;
  logic [8:0]  tsh_r, tsh_nxt, rsh_r, rsh_nxt;
  logic [3:0]  tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt;
  logic        txd_r, txd_nxt, rpar_r, rpar_nxt;
  logic [7:0]  rdat_r, rdat_nxt;
  logic        rx9_r, rx9_nxt, rxv_r, rxv_nxt, perr_r, perr_nxt;
  // Decoded controls
  logic        acc, fin, wr, rd, hit, sync_m, pol, pen, podd, tick;
  logic        tstep, rsmp, tload, rdone;
  logic [3:0]  nbits, os_m1, half;
  logic [8:0]  mask;
  logic [7:0]  shared_rd;
  assign acc    = psel & penable & ~pready_r;
  assign fin    = psel & penable & pready_r;
  assign wr     = fin & pwrite;
  assign rd     = fin & ~pwrite;
  assign sync_m = ffc_r[serial_cfg_pkg::MODE_BIT];          // [R5]
  assign pol    = ffc_r[serial_cfg_pkg::POL_BIT];
  assign pen    = ffc_r[serial_cfg_pkg::PEN_BIT];           // [R6]
  assign podd   = ffc_r[serial_cfg_pkg::PODD_BIT];          // [R6]
  assign os_m1  = u2x_r ? serial_cfg_pkg::OS_FAST_M1 : serial_cfg_pkg::OS_NORM_M1; // [R18]
  assign half   = u2x_r ? serial_cfg_pkg::HALF_FAST : serial_cfg_pkg::HALF_NORM;
  assign tick   = (pre_r == 12'h000);
  // Sync edges: change where xck equals polarity, sample on the other
  assign tstep  = sync_m ? (tick & (xck_r == pol)) : (tick & (txos_r == os_m1)); // [R13]
  assign rsmp   = sync_m ? (tick & (xck_r != pol)) : (tick & (rxos_r == os_m1)); // [R13]
  assign tload  = wr & (paddr == serial_cfg_pkg::ADDR_DATA) & txen_r & (tst_r == serial_cfg_pkg::T_IDLE);
  assign rdone  = rsmp & (rst_r == serial_cfg_pkg::R_STOP);
  assign shared_rd = shsel_r ? {4'h0, div_r[11:8]} : {1'b1, ffc_r};  // [R3] [R4] [R17]
  // Character size decode; reserved codes fall back to eight bits
  always_comb begin
    case ({csz2_r, ffc_r[2:1]})                              // [R11]
      3'h0:    nbits = 4'h5;
      3'h1:    nbits = 4'h6;
      3'h2:    nbits = 4'h7;
      3'h7:    nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
    for (int i = 0; i < 9; i++) begin
      mask[i] = (4'(i) < nbits);                             // [R19]
    end
  end
  // ----------------------------------------
  // APB register file
  // ----------------------------------------
  // Registers commit at the pready edge only, so a held request acts once
  always_comb begin
    ffc_nxt = ffc_r;
    div_nxt = div_r;
    rxen_nxt = rxen_r;
    txen_nxt = txen_r;
    csz2_nxt = csz2_r;
    tx9_nxt = tx9_r;
    u2x_nxt = u2x_r;
    shsel_nxt = shsel_r;
    pready_nxt = acc;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    hit = 1'b1;
    case (paddr)
      serial_cfg_pkg::ADDR_DATA:   prdata_nxt = {24'h0, rdat_r};
      serial_cfg_pkg::ADDR_STAT:   prdata_nxt = {24'h0, rxv_r, 1'b0,
                                    tst_r == serial_cfg_pkg::T_IDLE, 2'b0, perr_r, u2x_r, 1'b0};
      serial_cfg_pkg::ADDR_CTLB:   prdata_nxt = {27'h0, rxen_r, txen_r, csz2_r,
                                    rx9_r, tx9_r};           // [R1]
      serial_cfg_pkg::ADDR_SHARED: prdata_nxt = {24'h0, shared_rd};
      serial_cfg_pkg::ADDR_DIVL:   prdata_nxt = {24'h0, div_r[7:0]};
      default: begin
        prdata_nxt = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    if (acc) begin
      pslverr_nxt = ~hit;
    end else begin
      prdata_nxt = 32'h0000_0000;
      pslverr_nxt = 1'b0;
    end
    if (wr) begin
      case (paddr)
        serial_cfg_pkg::ADDR_STAT: u2x_nxt = pwdata[serial_cfg_pkg::U2X_BIT];
        serial_cfg_pkg::ADDR_CTLB: begin
          rxen_nxt = pwdata[serial_cfg_pkg::RXEN_BIT];
          txen_nxt = pwdata[serial_cfg_pkg::TXEN_BIT];
          csz2_nxt = pwdata[serial_cfg_pkg::CSZ2_BIT];
          tx9_nxt  = pwdata[serial_cfg_pkg::TX9_BIT];        // [R2]
        end
        serial_cfg_pkg::ADDR_SHARED: begin
          shsel_nxt = ~pwdata[serial_cfg_pkg::SEL_BIT];
          if (pwdata[serial_cfg_pkg::SEL_BIT]) begin
            ffc_nxt = pwdata[6:0];                           // [R3] [R21]
          end else begin
            div_nxt[11:8] = pwdata[3:0];                     // [R4] [R14] [R17]
          end
        end
        serial_cfg_pkg::ADDR_DIVL: div_nxt[7:0] = pwdata[7:0]; // [R14]
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // Baud prescaler and sync clock
  // ----------------------------------------
  // Down-counter of divisor plus one clocks per tick; a low write restarts it
  always_comb begin
    pre_nxt = tick ? div_r : pre_r - 12'h001;               // [R20]
    if (wr & (paddr == serial_cfg_pkg::ADDR_DIVL)) begin
      pre_nxt = {div_r[11:8], pwdata[7:0]};                  // [R15]
    end
    xck_nxt = sync_m ? (xck_r ^ tick) : pol;
    // Follows the mode bit on the same edge, so the enable is a plain flop
    xoe_n_nxt = ~ffc_nxt[serial_cfg_pkg::MODE_BIT];        // [R5]
    txos_nxt = txos_r;
    if (!sync_m & tick) begin
      txos_nxt = (txos_r == os_m1) ? 4'h0 : txos_r + 4'h1;  // [R18] [R20]
    end
  end
  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  // State names the next bit to drive; it is driven at the step edge
  always_comb begin
    tst_nxt = tst_r;
    tsh_nxt = tsh_r;
    tcnt_nxt = tcnt_r;
    txd_nxt = txd_r;
    case (tst_r)
      serial_cfg_pkg::T_IDLE: begin
        txd_nxt = 1'b1;
        if (tload) begin
          tsh_nxt = {tx9_r, pwdata[7:0]} & mask;            // [R2] [R19]
          tst_nxt = serial_cfg_pkg::T_START;
        end
      end
      serial_cfg_pkg::T_START: if (tstep) begin
        txd_nxt = 1'b0;
        tcnt_nxt = 4'h0;
        tst_nxt = serial_cfg_pkg::T_DATA;
      end
      serial_cfg_pkg::T_DATA: if (tstep) begin
        txd_nxt = tsh_r[tcnt_r];                             // [R11]
        tcnt_nxt = tcnt_r + 4'h1;
        if (tcnt_r == nbits - 4'h1) begin
          tst_nxt = pen ? serial_cfg_pkg::T_PAR : serial_cfg_pkg::T_STOP;
          tcnt_nxt = 4'h0;
        end
      end
      serial_cfg_pkg::T_PAR: if (tstep) begin
        txd_nxt = ^tsh_r ^ podd;                             // [R7]
        tst_nxt = serial_cfg_pkg::T_STOP;
      end
      serial_cfg_pkg::T_STOP: if (tstep) begin
        txd_nxt = 1'b1;
        if (ffc_r[serial_cfg_pkg::STOP_BIT] & (tcnt_r == 4'h0)) begin
          tcnt_nxt = 4'h1;                                   // [R9]
        end else begin
          tst_nxt = serial_cfg_pkg::T_END;
        end
      end
      serial_cfg_pkg::T_END: if (tstep) begin
        tst_nxt = serial_cfg_pkg::T_IDLE;
      end
      default: tst_nxt = serial_cfg_pkg::T_IDLE;
    endcase
  end
  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Async start is checked mid-bit to reject glitches; one stop bit only
  always_comb begin
    rst_nxt = rst_r;
    rsh_nxt = rsh_r;
    rcnt_nxt = rcnt_r;
    rpar_nxt = rpar_r;
    rxos_nxt = (!sync_m & tick) ? rxos_r + 4'h1 : rxos_r;
    if (rsmp) begin
      rxos_nxt = 4'h0;
    end
    rdat_nxt = rdat_r;
    rx9_nxt = rx9_r;
    perr_nxt = perr_r;
    rxv_nxt = rxv_r;
    if (rd & (paddr == serial_cfg_pkg::ADDR_DATA)) begin
      rxv_nxt = 1'b0;
    end
    case (rst_r)
      serial_cfg_pkg::R_IDLE: begin
        rxos_nxt = 4'h0;
        rsh_nxt = 9'h000;
        rcnt_nxt = 4'h0;
        if (rxen_r & !rxd) begin
          if (!sync_m) begin
            rst_nxt = serial_cfg_pkg::R_START;
          end else if (rsmp) begin
            rst_nxt = serial_cfg_pkg::R_DATA;
          end
        end
      end
      serial_cfg_pkg::R_START: if (tick & (rxos_r == half)) begin
        rxos_nxt = 4'h0;
        rst_nxt = rxd ? serial_cfg_pkg::R_IDLE : serial_cfg_pkg::R_DATA;
      end
      serial_cfg_pkg::R_DATA: if (rsmp) begin
        rsh_nxt[rcnt_r] = rxd;                               // [R11] [R19]
        rcnt_nxt = rcnt_r + 4'h1;
        if (rcnt_r == nbits - 4'h1) begin
          rst_nxt = pen ? serial_cfg_pkg::R_PAR : serial_cfg_pkg::R_STOP;
        end
      end
      serial_cfg_pkg::R_PAR: if (rsmp) begin
        rpar_nxt = rxd;
        rst_nxt = serial_cfg_pkg::R_STOP;
      end
      serial_cfg_pkg::R_STOP: if (rsmp) begin
        rst_nxt = serial_cfg_pkg::R_IDLE;                    // [R10]
      end
      default: rst_nxt = serial_cfg_pkg::R_IDLE;
    endcase
    // Completion wins over a same-cycle read clear
    if (rdone) begin
      rdat_nxt = rsh_r[7:0];
      rx9_nxt = rsh_r[8];                                    // [R1]
      perr_nxt = pen & ((^rsh_r ^ rpar_r) != podd);          // [R8]
      rxv_nxt = 1'b1;
    end
    if (!rxen_r) begin
      rst_nxt = serial_cfg_pkg::R_IDLE;
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ffc_r <= serial_cfg_pkg::FFC_RST;
      div_r <= serial_cfg_pkg::DIV_RST;
      {rxen_r, txen_r, csz2_r, tx9_r, u2x_r, shsel_r} <= 6'h00;
      prdata_r <= 32'h0000_0000;
      {pready_r, pslverr_r} <= 2'h0;
      pre_r <= serial_cfg_pkg::DIV_RST;
      {xck_r, rpar_r} <= 2'h0;
      xoe_n_r <= ~serial_cfg_pkg::FFC_RST[serial_cfg_pkg::MODE_BIT];
      {txos_r, rxos_r} <= 8'h00;
      tst_r <= serial_cfg_pkg::T_IDLE;
      rst_r <= serial_cfg_pkg::R_IDLE;
      {tsh_r, rsh_r} <= 18'h00000;
      {tcnt_r, rcnt_r} <= 8'h00;
      txd_r <= 1'b1;
      rdat_r <= 8'h00;
      {rx9_r, rxv_r, perr_r} <= 3'h0;
    end else begin
      ffc_r <= ffc_nxt;
      div_r <= div_nxt;
      {rxen_r, txen_r, csz2_r, tx9_r, u2x_r, shsel_r} <=
        {rxen_nxt, txen_nxt, csz2_nxt, tx9_nxt, u2x_nxt, shsel_nxt};
      prdata_r <= prdata_nxt;
      {pready_r, pslverr_r} <= {pready_nxt, pslverr_nxt};
      pre_r <= pre_nxt;
      {xck_r, rpar_r} <= {xck_nxt, rpar_nxt};
      xoe_n_r <= xoe_n_nxt;
      {txos_r, rxos_r} <= {txos_nxt, rxos_nxt};
      tst_r <= tst_nxt;
      rst_r <= rst_nxt;
      {tsh_r, rsh_r} <= {tsh_nxt, rsh_nxt};
      {tcnt_r, rcnt_r} <= {tcnt_nxt, rcnt_nxt};
      txd_r <= txd_nxt;
      rdat_r <= rdat_nxt;
      {rx9_r, rxv_r, perr_r} <= {rx9_nxt, rxv_nxt, perr_nxt};
    end
  end
  // Pin and bus outputs straight from flops; xck driven only in sync mode
  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign txd      = txd_r;
  assign xck_out  = xck_r;
  assign xck_oe_n = xoe_n_r;
endmodule : serial_frame_cfg

/* File: serial_cfg_pkg.sv */
// Purpose: Constants and state types shared by the serial transceiver core
// Assumes: 32-bit APB, byte offsets below are word aligned
// Notes:   Field positions are bit indexes within each register
package serial_cfg_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_STAT   = 8'h04;
  localparam logic [7:0] ADDR_CTLB   = 8'h08;
  localparam logic [7:0] ADDR_SHARED = 8'h0C;
  localparam logic [7:0] ADDR_DIVL   = 8'h10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SEL_BIT   = 7;
  localparam int MODE_BIT  = 6;
  localparam int PEN_BIT   = 5;
  localparam int PODD_BIT  = 4;
  localparam int STOP_BIT  = 3;
  localparam int POL_BIT   = 0;
  localparam int RXEN_BIT  = 4;
  localparam int TXEN_BIT  = 3;
  localparam int CSZ2_BIT  = 2;
  localparam int RX9_BIT   = 1;
  localparam int TX9_BIT   = 0;
  localparam int RXC_BIT   = 7;
  localparam int TXI_BIT   = 5;
  localparam int PE_BIT    = 2;
  localparam int U2X_BIT   = 1;
  // ----------------------------------------
  // Reset values and timing counts
  // ----------------------------------------
  localparam logic [6:0]  FFC_RST    = 7'h06;
  localparam logic [11:0] DIV_RST    = 12'h000;
  localparam logic [3:0]  OS_NORM_M1 = 4'hF;
  localparam logic [3:0]  OS_FAST_M1 = 4'h7;
  localparam logic [3:0]  HALF_NORM  = 4'h7;
  localparam logic [3:0]  HALF_FAST  = 4'h3;
  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  typedef enum logic [5:0] {
    T_IDLE = 6'h01, T_START = 6'h02, T_DATA = 6'h04,
    T_PAR = 6'h08, T_STOP = 6'h10, T_END = 6'h20
  } tx_state_t;
  typedef enum logic [4:0] {
    R_IDLE = 5'h01, R_START = 5'h02, R_DATA = 5'h04,
    R_PAR = 5'h08, R_STOP = 5'h10
  } rx_state_t;
endpackage : serial_cfg_pkg

/* File: serial_cfg_props.sv */
// Purpose: Port-level checks for the serial frame configuration block
// Assumes: Shared location is mirrored from committed APB writes
// Notes:   Mirrors update on the same edge as the design commits
`timescale 1ns/1ps
module serial_cfg_props (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txd,
  input wire logic        xck_out,
  input wire logic        xck_oe_n
);
  // ----------------------------------------
  // Shared location mirror
  // ----------------------------------------
  logic       sel_r;
  logic [6:0] ff_r;
  logic [3:0] dh_r;
  logic       wr_sh;
  logic       rd_sh;
  // Commit and read strobes at the shared location
  assign wr_sh = psel & penable & pready & pwrite & (paddr == serial_cfg_pkg::ADDR_SHARED);
  assign rd_sh = pready & ~pwrite & (paddr == serial_cfg_pkg::ADDR_SHARED);
  // Select bit steers each write to one register only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_r <= 1'b1;
      ff_r  <= 7'h06;
      dh_r  <= 4'h0;
    end else if (wr_sh) begin
      sel_r <= pwdata[7];
      if (pwdata[7]) ff_r <= pwdata[6:0];
      else dh_r <= pwdata[3:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ff_rd;
    rd_sh && sel_r |-> prdata[7:0] == {1'b1, ff_r};
  endproperty
  a_ff_rd: assert property (p_ff_rd)
    else $error("frame format read back differs");
  property p_dh_rd;
    rd_sh && !sel_r |-> prdata[7:0] == {4'h0, dh_r};
  endproperty
  a_dh_rd: assert property (p_dh_rd)
    else $error("divisor high read back differs");
  property p_mode;
    xck_oe_n == !ff_r[6];
  endproperty
  a_mode: assert property (p_mode)
    else $error("clock drive does not follow mode");
  property p_apol;
    !ff_r[6] |-> xck_out == ff_r[0];
  endproperty
  a_apol: assert property (p_apol)
    else $error("idle clock level not polarity");
  property p_sedge;
    ff_r[6] && $changed(txd) |-> xck_out != ff_r[0];
  endproperty
  a_sedge: assert property (p_sedge)
    else $error("sync data changed on wrong clock edge");
  property p_hi;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_hi: assert property (p_hi)
    else $error("upper read bits not zero");
  property p_wait;
    $rose(penable) && psel |-> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait)
    else $error("ready not after one wait state");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready held too long");
  property p_err;
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
  endproperty
  a_err: assert property (p_err)
    else $error("error response does not match map");
endmodule : serial_cfg_props
bind serial_frame_cfg serial_cfg_props u_props (
  .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .txd, .xck_out, .xck_oe_n
);

/* File: serial_line_partner.sv */
// Purpose: Remote transceiver on the serial lines
// Assumes: Bit time given in clocks by the caller
// Notes:   Always sends one stop bit, whatever the device expects
`timescale 1ns/1ps
module serial_line_partner (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;
  // Sample one frame at bit centres, LSB first
  task automatic recv(input int n, input int hp, input int ns, input int bc,
                      output logic [8:0] d, output logic p, output int ok);
    int k;
    d = 9'h000;
    p = 1'b0;
    ok = 1;
    k = 0;
    while (txd !== 1'b0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    repeat (bc / 2) @(posedge clk);
    if (txd !== 1'b0) ok = 0;
    for (int i = 0; i < n; i++) begin
      repeat (bc) @(posedge clk);
      d[i] = txd;
    end
    if (hp != 0) begin
      repeat (bc) @(posedge clk);
      p = txd;
    end
    for (int i = 0; i < ns; i++) begin
      repeat (bc) @(posedge clk);
      if (txd !== 1'b1) ok = 0;
    end
  endtask : recv
  // Drive one frame; caller enters right after a rising edge
  task automatic send(input logic [8:0] d, input int n, input int hp, input logic p,
                      input int bc);
    rxd <= 1'b0;
    repeat (bc) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (bc) @(posedge clk);
    end
    if (hp != 0) begin
      rxd <= p;
      repeat (bc) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (bc) @(posedge clk);
  endtask : send
endmodule : serial_line_partner

/* File: tb.sv */
// Purpose: Self-checking bench for frame format and rate setup
// Assumes: Divisor kept at one so an async bit lasts 32 or 16 clocks and a sync bit four
// Notes:   Shared location modelled with plain integers
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
  logic        clk, resetn, psel, penable, pwrite, rxd, txd, xck_out, xck_oe_n;
  logic        pready, pslverr, er, fp, ep;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv, c;
  logic [8:0]  fd;
  int          n_fail, checks, seed, ok, ff_m, dh_m, sel_m, bc, n, d, w;
  int          nb[7] = '{5, 6, 7, 8, 9, 8, 8};
  int          cz[7] = '{0, 1, 2, 3, 7, 3, 4};
  int          pm[7] = '{2, 3, 0, 2, 3, 1, 0};
  serial_frame_cfg dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
                        .prdata, .pready, .pslverr, .rxd, .txd, .xck_out, .xck_oe_n);
  serial_line_partner peer (.clk, .txd, .rxd);
  // Clock and hang guard
  always #20 clk = ~clk;
  initial begin
    #(40 * 40000);
    n_fail++;
    final_report();
  end
  task final_report;
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // One APB transfer; shared location model updated at commit
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dv;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_fail++;
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && a == serial_cfg_pkg::ADDR_SHARED) begin
      sel_m = dv[7];
      if (dv[7]) ff_m = dv[6:0];
      else dh_m = dv[3:0];
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rv, e)
  endtask : rd
  function automatic logic [31:0] shr();
    return sel_m ? (32'h80 | ff_m) : dh_m;
  endfunction : shr
  // Main sequence
  initial begin
    {clk, psel, penable, pwrite, paddr, pwdata, resetn} = '0;
    {n_fail, checks, dh_m} = '0;
    ff_m = 6;
    sel_m = 1;
    seed = 36082;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(serial_cfg_pkg::ADDR_SHARED, shr()); // reset value
    rd(serial_cfg_pkg::ADDR_STAT, 32'h20);
    rd(serial_cfg_pkg::ADDR_CTLB, 32'h0);
    rd(serial_cfg_pkg::ADDR_DIVL, 32'h0);
    rd(8'h14, 32'h0);
    `CHK(er, 1'b1)
    d = $random(seed) & 15;
    apb(1'b1, serial_cfg_pkg::ADDR_SHARED, 32'h70 | d);
    rd(serial_cfg_pkg::ADDR_SHARED, shr());
    apb(1'b1, serial_cfg_pkg::ADDR_SHARED, 32'h0);
    // Every size, parity and stop code except size codes 5 and 6, in both directions
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, serial_cfg_pkg::ADDR_SHARED,
          32'h80 | pm[i] << 4 | (i & 1) << 3 | (cz[i] & 3) << 1); // polarity zero
      rd(serial_cfg_pkg::ADDR_SHARED, shr());
      d = $random(seed) & 'h1FF;
      c = 32'h18 | (cz[i] >> 2) << 2 | d[8];
      apb(1'b1, serial_cfg_pkg::ADDR_CTLB, c); // ninth bit first
      apb(1'b1, serial_cfg_pkg::ADDR_STAT, (i >> 1 & 1) << 1);
      apb(1'b1, serial_cfg_pkg::ADDR_DIVL, 32'h1); // line idle
      bc = ((i >> 1 & 1) != 0 ? 8 : 16) * 2;
      n = nb[i];
      apb(1'b1, serial_cfg_pkg::ADDR_DATA, d & 'hFF);
      peer.recv(n, pm[i] >> 1, (i & 1) + 1, bc, fd, fp, ok);
      `CHK(ok, 1)
      `CHK(fd, 9'(d & ((1 << n) - 1)))
      ep = ^(d & ((1 << n) - 1)) ^ pm[i][0];
      if (pm[i] > 1) `CHK(fp, ep)
      // Reception with parity spoiled on odd entries 1 and 3; entry 5 has parity off
      d = $random(seed) & 'h1FF;
      ep = ^(d & ((1 << n) - 1)) ^ pm[i][0];
      peer.send(d, n, pm[i] >> 1, ep ^ (i & 1), bc);
      w = 0;
      do begin
        apb(1'b0, serial_cfg_pkg::ADDR_STAT, 32'h0);
        w++;
      end while (rv[7] !== 1'b1 && w < 100);
      `CHK(rv[7], 1'b1)
      `CHK(rv[2], logic'(pm[i] > 1 && (i & 1) != 0))
      apb(1'b0, serial_cfg_pkg::ADDR_CTLB, 32'h0);
      if (n == 9) `CHK(rv[1], d[8]) // ninth before data
      rd(serial_cfg_pkg::ADDR_DATA, d & ((1 << n) - 1) & 'hFF);
    end
    // Synchronous nine-bit frames with both polarities; a bit is four clocks
    apb(1'b1, serial_cfg_pkg::ADDR_STAT, 32'h0);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, serial_cfg_pkg::ADDR_SHARED, 32'hC6 | p);
      rd(serial_cfg_pkg::ADDR_SHARED, shr());
      d = $random(seed) & 'h1FF;
      apb(1'b1, serial_cfg_pkg::ADDR_CTLB, 32'h1C | d[8]);
      apb(1'b1, serial_cfg_pkg::ADDR_DATA, d & 'hFF);
      peer.recv(9, 0, 1, 4, fd, fp, ok);
      `CHK(ok, 1)
      `CHK(fd, 9'(d))
    end
    final_report();
  end
endmodule : tb
